// ==== include/qpc_pkg.sv ====
/*
  shared constants and types for the quadrature position counter.
  assumes encoder phase and index inputs are already synchronous to core_clk.
*/
package qpc_pkg;
  localparam int LINES_DEFAULT = 1024;
  localparam int EDGES_PER_LINE = 4;
  localparam int POS_WIDTH = 16;
  localparam int FRAC_WIDTH = 16;
  localparam logic [POS_WIDTH-1:0] POS_RESET = 16'h0000;
  localparam logic [POS_WIDTH-1:0] EXPECTED_INDEX_DEFAULT = 16'h0000;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [1:0] DECODE_RELOAD = 2'h0;

  typedef enum logic [1:0]
  {
    QPC_STEP_NONE,
    QPC_STEP_UP,
    QPC_STEP_DOWN
  } qpc_step_t;
endpackage : qpc_pkg

// ==== rtl/qpc_position_counter.sv ====
/*
  rotor position counter with index check and angle scaling.
  assumes encoder phases and index are synchronous to core_clk; phase reset
  state is 00 so the encoder should rest there or one spurious step may occur.
*/
`timescale 1ns/1ps
module qpc_position_counter
#(
  parameter int LINES = qpc_pkg::LINES_DEFAULT,
  parameter int POS_W = qpc_pkg::POS_WIDTH,
  parameter int FRAC_W = qpc_pkg::FRAC_WIDTH,
  parameter bit INDEX_CHECK = 1'b1,
  parameter logic [qpc_pkg::POS_WIDTH-1:0] EXPECTED_INDEX = qpc_pkg::EXPECTED_INDEX_DEFAULT
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic phaseA,
  input wire logic phaseB,
  input wire logic indexPulse,
  input wire logic errorClear,
  output logic signed [POS_W-1:0] position,
  output logic signed [POS_W-1:0] basicPosition,
  output logic signed [POS_W-1:0] indexCount,
  output logic indexSeen,
  output logic positionError,
  output logic signed [FRAC_W-1:0] angleFrac
);
  // compare limit and counts per revolution
  localparam logic signed [POS_W-1:0] LIMIT = POS_W'(qpc_pkg::EDGES_PER_LINE * LINES - 1);
  localparam logic signed [POS_W+FRAC_W-1:0] SPAN = (POS_W+FRAC_W)'(qpc_pkg::EDGES_PER_LINE * LINES);

  logic stepValid;
  logic stepUp;
  logic indexRise;
  logic signed [POS_W-1:0] cascade_q;
  logic signed [POS_W-1:0] cascade_d;
  logic signed [POS_W-1:0] basic_q;
  logic signed [POS_W-1:0] basic_d;
  logic signed [POS_W-1:0] idxCount_q;
  logic signed [POS_W-1:0] idxCount_d;
  logic idxSeen_q;
  logic idxSeen_d;
  logic index_q;
  logic index_d;
  logic error_q;
  logic error_d;
  logic signed [FRAC_W-1:0] frac_q;
  logic signed [FRAC_W-1:0] frac_d;
  // wide intermediate for the fraction divide
  logic signed [POS_W+FRAC_W-1:0] scaled;

  // decoder count stays internal; only step and direction leave the stage
  qpc_quad_decoder u_decoder
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .phaseA(phaseA),
    .phaseB(phaseB),
    .stepValid(stepValid),
    .stepUp(stepUp),
    .decodeCount()
  );

  // index edge detect; the register resets low like the idle pin
  always_comb
  begin
    index_d = indexPulse;
    indexRise = indexPulse && !index_q;
  end

  // cascaded stage: direction internal from decoder, not cleared by index
  always_comb
  begin
    cascade_d = cascade_q;
    // wrap on reaching either compare limit
    if (stepValid)
    begin
      if (stepUp)
      begin
        cascade_d = (cascade_q == LIMIT) ? POS_W'(0) : cascade_q + POS_W'(1);
      end
      else
      begin
        cascade_d = (cascade_q == -LIMIT) ? POS_W'(0) : cascade_q - POS_W'(1);
      end
    end
  end

  // basic counter, cleared by index once per revolution
  always_comb
  begin
    basic_d = basic_q;
    if (indexRise)
    begin
      basic_d = POS_W'(0);
    end
    else if (stepValid)
    begin
      basic_d = stepUp ? basic_q + POS_W'(1) : basic_q - POS_W'(1);
      // without the cascade this counter takes over its wrap limits
      if (!INDEX_CHECK && basic_q == (stepUp ? LIMIT : -LIMIT))
      begin
        basic_d = POS_W'(0);
      end
    end
  end

  // index capture and check; a new mismatch wins over clear
  always_comb
  begin
    idxCount_d = idxCount_q;
    idxSeen_d = idxSeen_q;
    error_d = error_q && !errorClear;
    // the capture sees the count before any step in the same cycle
    if (indexRise && INDEX_CHECK)
    begin
      idxCount_d = cascade_q;
      idxSeen_d = 1'b1;
      if (cascade_q != $signed(EXPECTED_INDEX[POS_W-1:0]))
      begin
        error_d = 1'b1;
      end
    end
  end

  // scale position by 2^(FRAC_W-1)/(4*lines); the divide truncates toward zero
  // registered, so the fraction follows position by one cycle
  always_comb
  begin
    scaled = (POS_W+FRAC_W)'(position) <<< (FRAC_W - 1);
    scaled = scaled / SPAN;
    frac_d = scaled[FRAC_W-1:0];
  end

  // cascade register
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      cascade_q <= qpc_pkg::POS_RESET;
    end
    else
    begin
      cascade_q <= cascade_d;
    end
  end

  // basic counter register
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      basic_q <= qpc_pkg::POS_RESET;
    end
    else
    begin
      basic_q <= basic_d;
    end
  end

  // index capture and error registers
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      idxCount_q <= qpc_pkg::POS_RESET;
      idxSeen_q <= 1'b0;
      error_q <= 1'b0;
    end
    else
    begin
      idxCount_q <= idxCount_d;
      idxSeen_q <= idxSeen_d;
      error_q <= error_d;
    end
  end

  // previous index level for the edge detect
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      index_q <= 1'b0;
    end
    else
    begin
      index_q <= index_d;
    end
  end

  // angle fraction register
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      frac_q <= '0;
    end
    else
    begin
      frac_q <= frac_d;
    end
  end

  // outputs straight from registers
  assign position = INDEX_CHECK ? cascade_q : basic_q;
  assign basicPosition = basic_q;
  assign indexCount = idxCount_q;
  assign indexSeen = idxSeen_q;
  assign positionError = error_q;
  assign angleFrac = frac_q;
endmodule : qpc_position_counter

// ==== rtl/qpc_quad_decoder.sv ====
/*
  first counter stage: decodes the two encoder phases into step and direction.
  assumes phaseA and phaseB are synchronous to core_clk and already debounced.
*/
`timescale 1ns/1ps
module qpc_quad_decoder
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic phaseA,
  input wire logic phaseB,
  output logic stepValid,
  output logic stepUp,
  output logic [1:0] decodeCount
);
  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic [1:0] decode_q;
  logic [1:0] decode_d;
  qpc_pkg::qpc_step_t step;

  // gray sequence 00-10-11-01 of phaseA,phaseB counts up when phaseA leads
  always_comb
  begin
    step = qpc_pkg::QPC_STEP_NONE;
    unique case ({phase_q, phaseA, phaseB})
      4'h1, 4'h7, 4'he, 4'h8: step = qpc_pkg::QPC_STEP_DOWN;
      4'h2, 4'hb, 4'hd, 4'h4: step = qpc_pkg::QPC_STEP_UP;
      default: step = qpc_pkg::QPC_STEP_NONE;
    endcase
  end

  always_comb
  begin
    phase_d = {phaseA, phaseB};
    decode_d = decode_q;
    if (step == qpc_pkg::QPC_STEP_UP)
    begin
      decode_d = (decode_q == 2'h3) ? qpc_pkg::DECODE_RELOAD : decode_q + 2'h1;
    end
    else if (step == qpc_pkg::QPC_STEP_DOWN)
    begin
      // counts toward zero and reloads on reaching it
      decode_d = (decode_q == qpc_pkg::DECODE_RELOAD) ? 2'h3 : decode_q - 2'h1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      phase_q <= qpc_pkg::PHASE_RESET;
      decode_q <= qpc_pkg::DECODE_RELOAD;
    end
    else
    begin
      phase_q <= phase_d;
      decode_q <= decode_d;
    end
  end

  assign stepValid = (step != qpc_pkg::QPC_STEP_NONE);
  assign stepUp = (step == qpc_pkg::QPC_STEP_UP);
  assign decodeCount = decode_q;
endmodule : qpc_quad_decoder

// ==== test/qpc_enc_model.sv ====
/* encoder model: gray phases and index
   assumes the bench calls step and index */
`timescale 1ns/1ps
module qpc_enc_model
(
  input wire logic core_clk,
  output logic phaseA,
  output logic phaseB,
  output logic indexPulse
);
  logic [1:0] st = 2'h0;
  assign phaseA = st[0] ^ st[1];
  assign phaseB = st[1];
  initial indexPulse = 1'b0;
  // d: 1 up, 3 down, 2 illegal jump
  task step(input int n, input logic [1:0] d);
    repeat (n)
    begin
      @(negedge core_clk) st = st + d;
      @(negedge core_clk);
    end
  endtask : step
  task index();
    @(negedge core_clk) indexPulse = 1'b1;
    @(negedge core_clk) indexPulse = 1'b0;
  endtask : index
endmodule : qpc_enc_model

// ==== test/qpc_position_counter_properties.sv ====
/* port checker of the position counter
   assumes the bind below */
`timescale 1ns/1ps
module qpc_position_counter_properties
#(
  parameter int LINES = 1024,
  parameter bit IDX = 1'b1,
  parameter logic [15:0] EXP = 16'h0000
)
(
  input logic core_clk,
  input logic nrst,
  input logic phaseA,
  input logic phaseB,
  input logic indexPulse,
  input logic errorClear,
  input logic signed [15:0] position,
  input logic signed [15:0] basicPosition,
  input logic signed [15:0] indexCount,
  input logic indexSeen,
  input logic positionError,
  input logic signed [15:0] angleFrac
);
  localparam logic [15:0] L = 16'(4 * LINES - 1);
  localparam logic [15:0] M = 16'(1 - 4 * LINES);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_up; $rose(phaseA) && !phaseB && position != L && (IDX || !$rose(indexPulse))
    |=> position == $past(position) + 1; endproperty
  a_up: assert property (p_up) else $error("up step");
  property p_dn; $rose(phaseB) && !phaseA && position != M && (IDX || !$rose(indexPulse))
    |=> position == $past(position) - 1; endproperty
  a_dn: assert property (p_dn) else $error("down step");
  property p_wrap; position == L
    && {$past(phaseA), $past(phaseB), phaseA, phaseB} inside {4'h2, 4'hb, 4'hd, 4'h4}
    |=> position == 0; endproperty
  a_wrap: assert property (p_wrap) else $error("wrap");
  property p_idx; $rose(indexPulse) |=> basicPosition == 0 && indexSeen == IDX; endproperty
  a_idx: assert property (p_idx) else $error("index clear");
  property p_cap; IDX && $rose(indexPulse) |=> indexCount == $past(position); endproperty
  a_cap: assert property (p_cap) else $error("index capture");
  property p_err; IDX && $rose(indexPulse) && position != EXP |=> positionError; endproperty
  a_err: assert property (p_err) else $error("index error");
  property p_ok; $rose(indexPulse) && position == EXP && !positionError
    |=> !positionError; endproperty
  a_ok: assert property (p_ok) else $error("index match");
  property p_plain; !IDX |-> position == basicPosition && !positionError; endproperty
  a_plain: assert property (p_plain) else $error("plain mode");
  property p_clr; errorClear && !$rose(indexPulse) |=> !positionError; endproperty
  a_clr: assert property (p_clr) else $error("error clear");
  property p_ang; angleFrac == 16'($past(position) * 32768 / (4 * LINES)); endproperty
  a_ang: assert property (p_ang) else $error("angle");
endmodule : qpc_position_counter_properties
bind qpc_position_counter qpc_position_counter_properties
  #(.LINES(LINES), .IDX(INDEX_CHECK), .EXP(EXPECTED_INDEX)) u_chk (.*);

// ==== test/tb_top.sv ====
/* self-checking bench of the position counter
   assumes the encoder model and checker */
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic errorClear = 1'b0;
  logic phaseA, phaseB, indexPulse, indexSeen, positionError;
  logic signed [15:0] position, basicPosition, indexCount, angleFrac;
  logic signed [15:0] plainPosition, plainBasic, plainIndexCount, plainAngle;
  logic plainSeen, plainError;
  int n_errors = 0;
  int total_checks = 0;
  always #12.5 core_clk = ~core_clk;
  qpc_enc_model enc (.*);
  qpc_position_counter #(.LINES(2)) dut (.*);
  qpc_position_counter #(.LINES(2), .INDEX_CHECK(1'b0)) dutPlain
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .phaseA(phaseA),
    .phaseB(phaseB),
    .indexPulse(indexPulse),
    .errorClear(errorClear),
    .position(plainPosition),
    .basicPosition(plainBasic),
    .indexCount(plainIndexCount),
    .indexSeen(plainSeen),
    .positionError(plainError),
    .angleFrac(plainAngle)
  );
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task chk_pos(input logic [15:0] p, input logic [15:0] b, input logic [15:0] a,
    input logic [15:0] q);
    repeat (4) @(negedge core_clk);
    chk("position", position, p);
    chk("basicPosition", basicPosition, b);
    chk("angleFrac", angleFrac, a);
    chk("plainPosition", plainPosition, q);
  endtask : chk_pos
  task t_reset();
    chk_pos(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    chk("positionError", positionError, 16'h0000);
    $display("reset done");
  endtask : t_reset
  task t_up();
    enc.step(9, 2'h1);
    chk_pos(16'h0001, 16'h0009, 16'h1000, 16'h0001);
    $display("up done");
  endtask : t_up
  task t_down();
    enc.step(3, 2'h3);
    chk_pos(16'hfffe, 16'h0006, 16'he000, 16'hfffe);
    $display("down done");
  endtask : t_down
  task t_jump();
    enc.step(1, 2'h2);
    chk_pos(16'hfffe, 16'h0006, 16'he000, 16'hfffe);
    $display("jump done");
  endtask : t_jump
  task t_index();
    enc.index();
    chk_pos(16'hfffe, 16'h0000, 16'he000, 16'h0000);
    chk("indexCount", indexCount, 16'hfffe);
    chk("indexSeen", indexSeen, 16'h0001);
    chk("positionError", positionError, 16'h0001);
    @(negedge core_clk) errorClear = 1'b1;
    @(negedge core_clk) errorClear = 1'b0;
    chk("positionError", positionError, 16'h0000);
    enc.step(2, 2'h1);
    enc.index();
    chk_pos(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    chk("indexCount", indexCount, 16'h0000);
    chk("positionError", positionError, 16'h0000);
    $display("index done");
  endtask : t_index
  task wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    t_reset();
    t_up();
    t_down();
    t_jump();
    t_index();
    wrap_up();
  end
endmodule : tb_top
